// ### core/panel_seq_pkg.sv
package panel_seq_pkg;

	// Clock rate and derived cycle counts.
	localparam int CLK_HZ = 25000000;
	localparam int CNT_W = 24;
	// Power-on readiness bound in milliseconds.
	localparam int READY_MS = 90;
	localparam int READY_CYCLES = (CLK_HZ / 1000) * READY_MS;
	// Power-down pin exit pulse on the reset pin, in microseconds.
	localparam int RESET_PULSE_US = 10;
	localparam int RESET_PULSE_CYCLES = (CLK_HZ / 1000000) * RESET_PULSE_US;

	// Power register values written by the source.
	localparam logic [2:0] POWER_D0 = 3'h1;
	localparam logic [2:0] POWER_D3 = 3'h2;

	// Default sequencing interval counts.
	localparam logic [CNT_W-1:0] DEF_POWER_TO_VIDEO = 24'h000010;
	localparam logic [CNT_W-1:0] DEF_VIDEO_TO_BACKLIGHT = 24'h000010;
	localparam logic [CNT_W-1:0] DEF_BACKLIGHT_OFF = 24'h000010;
	localparam logic [CNT_W-1:0] DEF_VIDEO_STOP = 24'h000010;
	localparam logic [CNT_W-1:0] DEF_OFF_MIN = 24'h000010;
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

	// Programmable interval set.
	typedef struct packed {
		logic [CNT_W-1:0] power_to_video_delay;
		logic [CNT_W-1:0] video_to_backlight_delay;
		logic [CNT_W-1:0] backlight_off_to_video_stop;
		logic [CNT_W-1:0] video_stop_to_power_off;
		logic [CNT_W-1:0] power_off_min_time;
	} timing_type;

	// Panel-facing outputs.
	typedef struct packed {
		logic panel_power_enable_out;
		logic backlight_enable_out;
		logic lvds_drive;
		logic lvds_weak_pull;
	} panel_type;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_POWER_UP = 3'h1,
		ST_BACKLIGHT_WAIT = 3'h2,
		ST_RUN = 3'h3,
		ST_BACKLIGHT_OFF = 3'h4,
		ST_VIDEO_STOP = 3'h5,
		ST_OFF_HOLD = 3'h6
	} seq_state_type;

	typedef enum logic [1:0] {
		PM_ACTIVE = 2'h0,
		PM_LOW_POWER = 2'h1,
		PM_DEEP = 2'h2
	} pm_state_type;

endpackage : panel_seq_pkg

// ### core/panel_power_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module panel_power_sequencer #(
	parameter int SUPPLY_HOLD_CYCLES = 1000,
	parameter int RESET_DELAY_CYCLES = 1000,
	parameter int DIP_FILTER_CYCLES = 100
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic SUPPLY_OK,
	input wire logic SUPPLY_LOW,
	input wire logic POWER_DOWN_IN_LOW,
	input wire logic EDID_EMULATION_SELECT_PIN,
	input wire logic VIDEO_PRESENT,
	input wire logic VIDEO_LOCKED,
	input wire logic POWER_WRITE,
	input wire logic [2:0] POWER_VALUE,
	input wire logic TIMING_WRITE,
	input wire panel_seq_pkg::timing_type TIMING_IN,
	input wire logic EMULATION_WRITE,
	input wire logic EMULATION_VALUE,
	output panel_seq_pkg::panel_type PANEL,
	output logic HOT_PLUG_OUT,
	output logic SINK_LOCKED,
	output logic CORE_RESET_LOW,
	output logic I2C_ENABLE,
	output logic AUX_ENABLE,
	output logic EDID_FROM_INTERNAL,
	output logic [1:0] POWER_STATE
);

	// Two-flop synchronisers for every pin-side input except RST.
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	always_ff @(posedge CLK) begin
		sync_a <= {SUPPLY_OK, SUPPLY_LOW, POWER_DOWN_IN_LOW,
			EDID_EMULATION_SELECT_PIN, VIDEO_PRESENT, VIDEO_LOCKED};
		sync_b <= sync_a;
	end
	logic supply_ok;
	logic supply_low;
	logic pd_low;
	logic emu_pin;
	logic video_ok;
	assign supply_ok = sync_b[5];
	assign supply_low = sync_b[4];
	assign pd_low = !sync_b[3];
	assign emu_pin = sync_b[2];
	assign video_ok = sync_b[1] && sync_b[0];

	// Power-on reset filter: hold time then delay, and dip filter.
	localparam int CNT_W_L = 32;
	logic [CNT_W_L-1:0] por_cnt, next_por_cnt;
	logic por_release, next_por_release;
	logic por_armed, next_por_armed;
	always_comb begin
		next_por_cnt = por_cnt;
		next_por_release = por_release;
		next_por_armed = por_armed;
		if (!por_release) begin
			if (!supply_ok) begin
				next_por_cnt = '0;
				next_por_armed = 1'b0;
			end else if (!por_armed) begin
				next_por_cnt = por_cnt + 32'h1;
				if (por_cnt >= 32'(SUPPLY_HOLD_CYCLES)) begin
					next_por_armed = 1'b1;
					next_por_cnt = '0;
				end
			end else begin
				next_por_cnt = por_cnt + 32'h1;
				if (por_cnt >= 32'(RESET_DELAY_CYCLES)) begin
					next_por_release = 1'b1;
					next_por_cnt = '0;
				end
			end
		end else if (supply_low) begin
			next_por_cnt = por_cnt + 32'h1;
			if (por_cnt >= 32'(DIP_FILTER_CYCLES)) begin
				next_por_release = 1'b0;
				next_por_armed = 1'b0;
				next_por_cnt = '0;
			end
		end else begin
			next_por_cnt = '0; // Short dips are forgotten.
		end
	end
	// Starts asserted so all logic below waits for a stable supply.
	always_ff @(posedge CLK) begin
		if (RST) begin
			por_cnt <= '0;
			por_release <= 1'b0;
			por_armed <= 1'b0;
		end else begin
			por_cnt <= next_por_cnt;
			por_release <= next_por_release;
			por_armed <= next_por_armed;
		end
	end
	logic core_rst;
	assign core_rst = RST || !por_release;
	// Start-up watch: a hold or delay too long for the ready bound trips it.
	logic [31:0] up_cnt, next_up_cnt;
	always_comb next_up_cnt = (!supply_ok || !core_rst) ? '0 : up_cnt + 32'h1;
	always_ff @(posedge CLK) up_cnt <= RST ? '0 : next_up_cnt;
	ready_time_a: assert property (@(posedge CLK) disable iff (RST)
		up_cnt < 32'(panel_seq_pkg::READY_CYCLES))
		else $error("Core reset held past the start-up bound.");

	// Power management and configuration registers.
	panel_seq_pkg::pm_state_type pm, next_pm;
	panel_seq_pkg::timing_type tm, next_tm;
	logic emu_reg, next_emu_reg;
	logic emu_pin_seen, next_emu_pin_seen;
	always_comb begin
		next_pm = pm;
		next_tm = tm;
		next_emu_reg = emu_reg;
		next_emu_pin_seen = emu_pin_seen;
		case (pm)
			panel_seq_pkg::PM_ACTIVE: begin
				if (POWER_WRITE && POWER_VALUE == panel_seq_pkg::POWER_D3)
					next_pm = panel_seq_pkg::PM_LOW_POWER;
			end
			panel_seq_pkg::PM_LOW_POWER: begin
				if (POWER_WRITE && POWER_VALUE == panel_seq_pkg::POWER_D0)
					next_pm = panel_seq_pkg::PM_ACTIVE;
			end
			panel_seq_pkg::PM_DEEP: begin
				if (!pd_low) begin
					next_pm = panel_seq_pkg::PM_ACTIVE;
					next_emu_pin_seen = 1'b0; // Pins resampled on exit.
				end
			end
			default: next_pm = panel_seq_pkg::PM_ACTIVE;
		endcase
		if (pd_low)
			next_pm = panel_seq_pkg::PM_DEEP;
		// Sample the select pin once per start; it overrides stored value.
		if (!emu_pin_seen && !pd_low) begin
			next_emu_reg = !emu_pin;
			next_emu_pin_seen = 1'b1;
		end
		if (pm != panel_seq_pkg::PM_DEEP) begin
			if (TIMING_WRITE)
				next_tm = TIMING_IN;
			if (EMULATION_WRITE && emu_pin_seen)
				next_emu_reg = EMULATION_VALUE;
		end
	end
	always_ff @(posedge CLK) begin
		if (core_rst) begin
			pm <= panel_seq_pkg::PM_ACTIVE;
			tm <= {panel_seq_pkg::DEF_POWER_TO_VIDEO,
				panel_seq_pkg::DEF_VIDEO_TO_BACKLIGHT,
				panel_seq_pkg::DEF_BACKLIGHT_OFF,
				panel_seq_pkg::DEF_VIDEO_STOP,
				panel_seq_pkg::DEF_OFF_MIN};
			emu_reg <= 1'b0;
			emu_pin_seen <= 1'b0;
		end else begin
			pm <= next_pm;
			tm <= next_tm;
			emu_reg <= next_emu_reg;
			emu_pin_seen <= next_emu_pin_seen;
		end
	end

	// Panel sequencing state machine with one shared interval counter.
	panel_seq_pkg::seq_state_type st, next_st;
	logic [panel_seq_pkg::CNT_W-1:0] cnt, next_cnt;
	logic want_on;
	logic done;
	assign want_on = (pm == panel_seq_pkg::PM_ACTIVE) && video_ok;
	assign done = (cnt == panel_seq_pkg::CNT_ZERO);
	always_comb begin
		next_st = st;
		next_cnt = done ? cnt : cnt - panel_seq_pkg::CNT_ONE;
		case (st)
			panel_seq_pkg::ST_OFF: begin
				if (want_on) begin
					next_st = panel_seq_pkg::ST_POWER_UP;
					next_cnt = tm.power_to_video_delay;
				end
			end
			panel_seq_pkg::ST_POWER_UP: begin
				if (!want_on) begin
					next_st = panel_seq_pkg::ST_VIDEO_STOP;
					next_cnt = tm.video_stop_to_power_off;
				end else if (done) begin
					next_st = panel_seq_pkg::ST_BACKLIGHT_WAIT;
					next_cnt = tm.video_to_backlight_delay;
				end
			end
			panel_seq_pkg::ST_BACKLIGHT_WAIT: begin
				if (!want_on) begin
					next_st = panel_seq_pkg::ST_VIDEO_STOP;
					next_cnt = tm.video_stop_to_power_off;
				end else if (done)
					next_st = panel_seq_pkg::ST_RUN;
			end
			panel_seq_pkg::ST_RUN: begin
				if (pm != panel_seq_pkg::PM_ACTIVE) begin
					next_st = panel_seq_pkg::ST_BACKLIGHT_OFF;
					next_cnt = tm.backlight_off_to_video_stop;
				end else if (!video_ok) begin
					next_st = panel_seq_pkg::ST_VIDEO_STOP;
					next_cnt = tm.video_stop_to_power_off;
				end
			end
			panel_seq_pkg::ST_BACKLIGHT_OFF: begin
				if (done || !video_ok) begin
					next_st = panel_seq_pkg::ST_VIDEO_STOP;
					next_cnt = tm.video_stop_to_power_off;
				end
			end
			panel_seq_pkg::ST_VIDEO_STOP: begin
				if (done) begin
					next_st = panel_seq_pkg::ST_OFF_HOLD;
					next_cnt = tm.power_off_min_time;
				end
			end
			panel_seq_pkg::ST_OFF_HOLD: begin
				if (done)
					next_st = panel_seq_pkg::ST_OFF;
			end
			default: next_st = panel_seq_pkg::ST_OFF;
		endcase
		// Deep power-down abandons the sequence at once, by design.
		if (pm == panel_seq_pkg::PM_DEEP && st != panel_seq_pkg::ST_OFF &&
			st != panel_seq_pkg::ST_OFF_HOLD) begin
			next_st = panel_seq_pkg::ST_OFF_HOLD;
			next_cnt = tm.power_off_min_time;
		end
	end
	always_ff @(posedge CLK) begin
		if (core_rst) begin
			st <= panel_seq_pkg::ST_OFF;
			cnt <= panel_seq_pkg::CNT_ZERO;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
		end
	end

	// Registered outputs derived from the states.
	panel_seq_pkg::panel_type next_panel;
	always_comb begin
		next_panel.panel_power_enable_out = (st == panel_seq_pkg::ST_POWER_UP) ||
			(st == panel_seq_pkg::ST_BACKLIGHT_WAIT) ||
			(st == panel_seq_pkg::ST_RUN) ||
			(st == panel_seq_pkg::ST_BACKLIGHT_OFF) ||
			(st == panel_seq_pkg::ST_VIDEO_STOP);
		next_panel.lvds_drive = (st == panel_seq_pkg::ST_BACKLIGHT_WAIT) ||
			(st == panel_seq_pkg::ST_RUN) ||
			(st == panel_seq_pkg::ST_BACKLIGHT_OFF);
		next_panel.backlight_enable_out = (st == panel_seq_pkg::ST_RUN) &&
			(pm == panel_seq_pkg::PM_ACTIVE);
		next_panel.lvds_weak_pull = !next_panel.lvds_drive;
	end
	always_ff @(posedge CLK) begin
		if (core_rst) begin
			PANEL <= '{1'b0, 1'b0, 1'b0, 1'b1};
			HOT_PLUG_OUT <= 1'b0;
			SINK_LOCKED <= 1'b0;
			I2C_ENABLE <= 1'b0;
			AUX_ENABLE <= 1'b0;
			EDID_FROM_INTERNAL <= 1'b0;
			POWER_STATE <= 2'h0;
		end else begin
			PANEL <= next_panel;
			HOT_PLUG_OUT <= (pm != panel_seq_pkg::PM_DEEP) && emu_pin_seen;
			SINK_LOCKED <= next_panel.lvds_drive && video_ok;
			I2C_ENABLE <= (pm == panel_seq_pkg::PM_ACTIVE);
			AUX_ENABLE <= (pm != panel_seq_pkg::PM_DEEP);
			EDID_FROM_INTERNAL <= emu_reg;
			POWER_STATE <= pm;
		end
	end
	assign CORE_RESET_LOW = !core_rst;

	// Checks on sequencing order and power-management states.
	power_first_a: assert property (@(posedge CLK) disable iff (core_rst)
		PANEL.lvds_drive |-> PANEL.panel_power_enable_out)
		else $error("LVDS driven without panel power.");
	light_video_a: assert property (@(posedge CLK) disable iff (core_rst)
		PANEL.backlight_enable_out |-> PANEL.lvds_drive)
		else $error("Backlight on without video.");
	deep_dark_a: assert property (@(posedge CLK) disable iff (core_rst)
		pm == panel_seq_pkg::PM_DEEP |=> !PANEL.backlight_enable_out)
		else $error("Backlight on in deep power-down.");
	low_quiet_a: assert property (@(posedge CLK) disable iff (core_rst)
		pm == panel_seq_pkg::PM_LOW_POWER |=> !I2C_ENABLE)
		else $error("I2C enabled in low power.");
	off_hold_a: assert property (@(posedge CLK) disable iff (core_rst)
		$fell(PANEL.panel_power_enable_out) |-> !PANEL.panel_power_enable_out [*2])
		else $error("Panel power re-raised too soon.");
	d3_entry_a: assert property (@(posedge CLK) disable iff (core_rst)
		(pm == panel_seq_pkg::PM_ACTIVE && !pd_low && POWER_WRITE &&
		POWER_VALUE == panel_seq_pkg::POWER_D3) |=>
		pm == panel_seq_pkg::PM_LOW_POWER)
		else $error("D3 write not honoured.");
	d0_exit_a: assert property (@(posedge CLK) disable iff (core_rst)
		(pm == panel_seq_pkg::PM_LOW_POWER && !pd_low && POWER_WRITE &&
		POWER_VALUE == panel_seq_pkg::POWER_D0) |=>
		pm == panel_seq_pkg::PM_ACTIVE)
		else $error("D0 write not honoured.");
	backlight_first_a: assert property (@(posedge CLK) disable iff (core_rst)
		st == panel_seq_pkg::ST_BACKLIGHT_OFF |=> !PANEL.backlight_enable_out)
		else $error("Backlight still on during shutdown.");
	run_c: cover property (@(posedge CLK) st == panel_seq_pkg::ST_RUN);
	d3_c: cover property (@(posedge CLK) st == panel_seq_pkg::ST_BACKLIGHT_OFF);
	deep_c: cover property (@(posedge CLK) pm == panel_seq_pkg::PM_DEEP);
endmodule : panel_power_sequencer
`default_nettype wire

// ### dv/dp_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural video source on the far side of the bridge.
module dp_source_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic hot_plug,
	input wire logic panel_power,
	input wire logic stream_en,
	input wire logic sync_loss,
	input wire logic pwr_req,
	input wire logic [2:0] pwr_val,
	output logic video_present,
	output logic video_locked,
	output logic power_write,
	output logic [2:0] power_value
);
	logic streaming;
	logic last_req;

	// Stream only after hot-plug, and keep it going while panel power is up.
	always_ff @(posedge clk) begin
		if (rst) begin
			streaming <= 1'b0;
		end else begin
			streaming <= hot_plug && (stream_en || (streaming && panel_power));
		end
	end

	assign video_present = streaming;
	assign video_locked = streaming && !sync_loss;

	// One write pulse per request; the value bus toggles between writes so
	// that a design latching it outside the pulse is caught.
	always_ff @(posedge clk) begin
		if (rst) begin
			last_req <= 1'b0;
			power_write <= 1'b0;
			power_value <= 3'h0;
		end else begin
			last_req <= pwr_req;
			power_write <= pwr_req && !last_req;
			power_value <= (pwr_req && !last_req) ? pwr_val : ~power_value;
		end
	end
endmodule : dp_source_model
`default_nettype wire

// ### dv/panel_power_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module panel_power_sequencer_tb;
	localparam logic [23:0] P2V = 24'h000008;
	localparam logic [23:0] V2B = 24'h000006;
	localparam logic [23:0] BOFF = 24'h000005;
	localparam logic [23:0] VSTOP = 24'h000007;
	localparam logic [23:0] OFFMIN = 24'h00000a;
	logic clk, rst, supply_ok, supply_low, pd_low, emu_pin, emu_write;
	logic emu_value, timing_write, stream_en, sync_loss, pwr_req;
	logic video_present, video_locked, power_write;
	logic hot_plug, sink_locked, core_reset_low, i2c_enable, aux_enable;
	logic edid_internal;
	logic [2:0] power_value, pwr_val;
	logic [1:0] power_state;
	panel_seq_pkg::timing_type timing_in;
	panel_seq_pkg::panel_type panel;
	int miscompares = 0;
	int n_tests = 0;
	int n, t_off;
	int cyc = 0;

	panel_power_sequencer #(.SUPPLY_HOLD_CYCLES(4), .RESET_DELAY_CYCLES(4),
		.DIP_FILTER_CYCLES(4)) dut (.CLK(clk), .RST(rst),
		.SUPPLY_OK(supply_ok), .SUPPLY_LOW(supply_low),
		.POWER_DOWN_IN_LOW(pd_low), .EDID_EMULATION_SELECT_PIN(emu_pin),
		.VIDEO_PRESENT(video_present), .VIDEO_LOCKED(video_locked),
		.POWER_WRITE(power_write), .POWER_VALUE(power_value),
		.TIMING_WRITE(timing_write), .TIMING_IN(timing_in),
		.EMULATION_WRITE(emu_write), .EMULATION_VALUE(emu_value),
		.PANEL(panel), .HOT_PLUG_OUT(hot_plug), .SINK_LOCKED(sink_locked),
		.CORE_RESET_LOW(core_reset_low), .I2C_ENABLE(i2c_enable),
		.AUX_ENABLE(aux_enable), .EDID_FROM_INTERNAL(edid_internal),
		.POWER_STATE(power_state));

	dp_source_model source (.clk(clk), .rst(rst), .hot_plug(hot_plug),
		.panel_power(panel.panel_power_enable_out), .stream_en(stream_en),
		.sync_loss(sync_loss), .pwr_req(pwr_req), .pwr_val(pwr_val),
		.video_present(video_present), .video_locked(video_locked),
		.power_write(power_write), .power_value(power_value));

	// Free-running 25 MHz clock and a cycle count for interval checks.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic sig(input int s);
		case (s)
			0: return panel.panel_power_enable_out;
			1: return panel.backlight_enable_out;
			2: return panel.lvds_drive;
			3: return hot_plug;
			default: return core_reset_low;
		endcase
	endfunction : sig

	// Called at a falling edge; counts falling edges until the level shows.
	task automatic wait_level(input int s, input logic v, output int k);
		k = 0;
		while (sig(s) !== v && k < 4000) begin
			@(negedge clk);
			k++;
		end
		check(k < 4000, 1'b1);
	endtask : wait_level

	task automatic power_cmd(input logic [2:0] v);
		@(posedge clk);
		pwr_val <= v;
		pwr_req <= 1'b1;
		repeat (2) @(posedge clk);
		pwr_req <= 1'b0;
		repeat (2) @(negedge clk);
	endtask : power_cmd

	task automatic test_reset();
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check(core_reset_low, 1'b0);
		wait_level(4, 1'b1, n);
		check(n >= 8 && n <= 16, 1'b1);
		wait_level(3, 1'b1, n);
		check(n <= 4, 1'b1);
		check(edid_internal, 1'b1);
		// A short dip must be filtered, a long one must reset the core.
		@(posedge clk);
		supply_low <= 1'b1;
		repeat (2) @(posedge clk);
		supply_low <= 1'b0;
		repeat (8) @(negedge clk);
		check(core_reset_low, 1'b1);
		@(posedge clk);
		supply_low <= 1'b1;
		supply_ok <= 1'b0;
		@(negedge clk);
		wait_level(4, 1'b0, n);
		check(n >= 4 && n <= 10, 1'b1);
		@(posedge clk);
		supply_low <= 1'b0;
		supply_ok <= 1'b1;
		@(negedge clk);
		wait_level(3, 1'b1, n);
		@(posedge clk);
		timing_in <= '{P2V, V2B, BOFF, VSTOP, OFFMIN};
		timing_write <= 1'b1;
		@(posedge clk);
		timing_write <= 1'b0;
		$display("test_reset done");
	endtask : test_reset

	task automatic test_power_up();
		@(posedge clk);
		stream_en <= 1'b1;
		@(negedge clk);
		wait_level(0, 1'b1, n);
		check(n <= 8, 1'b1);
		wait_level(2, 1'b1, n);
		check(n >= P2V && n <= P2V + 3, 1'b1);
		wait_level(1, 1'b1, n);
		check(n >= V2B && n <= V2B + 3, 1'b1);
		check(sink_locked, 1'b1);
		$display("test_power_up done");
	endtask : test_power_up

	task automatic test_low_power();
		@(posedge clk);
		stream_en <= 1'b0;
		power_cmd(panel_seq_pkg::POWER_D3);
		wait_level(1, 1'b0, n);
		check(panel.lvds_drive, 1'b1);
		wait_level(2, 1'b0, n);
		check(n >= BOFF - 4 && n <= BOFF + 3, 1'b1);
		wait_level(0, 1'b0, n);
		t_off = cyc;
		check(n >= VSTOP && n <= VSTOP + 3, 1'b1);
		check(power_state, 2'h1);
		check(i2c_enable, 1'b0);
		check(aux_enable & hot_plug, 1'b1);
		check(panel.lvds_weak_pull, 1'b1);
		@(posedge clk);
		stream_en <= 1'b1;
		power_cmd(panel_seq_pkg::POWER_D0);
		check(power_state, 2'h0);
		wait_level(0, 1'b1, n);
		check(cyc - t_off >= OFFMIN && cyc - t_off <= OFFMIN + 14, 1'b1);
		wait_level(1, 1'b1, n);
		$display("test_low_power done");
	endtask : test_low_power

	task automatic test_sync_loss();
		@(posedge clk);
		sync_loss <= 1'b1;
		@(negedge clk);
		wait_level(0, 1'b0, n);
		check(n >= VSTOP && n <= VSTOP + BOFF + 8, 1'b1);
		check(panel.backlight_enable_out, 1'b0);
		@(posedge clk);
		sync_loss <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			emu_value <= i[0];
			emu_write <= 1'b1;
			@(posedge clk);
			emu_write <= 1'b0;
			repeat (2) @(negedge clk);
			check(edid_internal, i[0]);
		end
		$display("test_sync_loss done");
	endtask : test_sync_loss

	task automatic test_deep();
		@(posedge clk);
		pd_low <= 1'b0;
		emu_pin <= 1'b1;
		repeat (6) @(negedge clk);
		check(power_state, 2'h2);
		check(panel.backlight_enable_out, 1'b0);
		check(panel.lvds_weak_pull, 1'b1);
		check({aux_enable, hot_plug, i2c_enable}, 3'h0);
		power_cmd(panel_seq_pkg::POWER_D0);
		check(power_state, 2'h2);
		// Exit: pin high first, then a reset pulse of the required width.
		@(posedge clk);
		pd_low <= 1'b1;
		@(posedge clk);
		rst <= 1'b1;
		repeat (panel_seq_pkg::RESET_PULSE_CYCLES) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		wait_level(3, 1'b1, n);
		check(power_state, 2'h0);
		check(edid_internal, 1'b0);
		$display("test_deep done");
	endtask : test_deep

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	// The whole run needs about 500 cycles; the 7500-cycle limit allows about fifteen times that.
	initial begin
		#300000;
		miscompares++;
		$display("Error at %0t: watchdog expired", $time);
		summarize();
	end

	initial begin
		rst = 1'b1;
		supply_ok = 1'b1;
		supply_low = 1'b0;
		pd_low = 1'b1;
		emu_pin = 1'b0;
		emu_write = 1'b0;
		emu_value = 1'b0;
		timing_write = 1'b0;
		timing_in = '0;
		stream_en = 1'b0;
		sync_loss = 1'b0;
		pwr_req = 1'b0;
		pwr_val = 3'h0;
		test_reset();
		test_power_up();
		test_low_power();
		test_sync_loss();
		test_deep();
		summarize();
	end
endmodule : panel_power_sequencer_tb
`default_nettype wire
